// [logic/annunciator_defines.svh]
`ifndef ANNUNCIATOR_DEFINES_SVH
`define ANNUNCIATOR_DEFINES_SVH

`define CLK_HZ 25_000_000
`define LOGIC_PERIOD_MS 100
`define LOGIC_PERIOD_CYC ((`CLK_HZ / 1000) * `LOGIC_PERIOD_MS)
`define HB_PERIOD_MS 10
`define HB_PERIOD_CYC ((`CLK_HZ / 1000) * `HB_PERIOD_MS)
`define TIME_PERIOD_MS 1000
`define TIME_PERIOD_CYC ((`CLK_HZ / 1000) * `TIME_PERIOD_MS)
`define LOG_DEPTH 4095
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_FAULT_LATCH 8'h08
`define REG_ALARM_LATCH 8'h0c
`define REG_LOG_COUNT 8'h10
`define REG_LOG_INDEX 8'h14
`define REG_LOG_DATA 8'h18
`define REG_PAGE_COUNT 8'h1c
`define REG_PAGE_POS 8'h20
`define REG_TIME 8'h24
`define CTRL_RUN_BIT 0
`define CTRL_LOG_CLR_BIT 1
`define CTRL_RESET 32'h0000_0001
`define FAULT_CTRL_BIT 0
`define FAULT_LOOP_BIT 1
`define FAULT_OFFLINE_BIT 2

`endif

// [logic/annunciator_pkg.sv]
package annunciator_pkg;
   typedef struct packed
   {
      logic [31:0] adr;
      logic [31:0] dat;
      logic [3:0] sel;
      logic we;
      logic cyc;
      logic stb;
   } wb_req_t;

   typedef struct packed
   {
      logic [31:0] dat;
      logic ack;
   } wb_rsp_t;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_DONE = 2'b11
   } exec_state_t;

   typedef struct packed
   {
      logic alarm;
      logic fault;
      logic [15:0] cond;
   } log_entry_t;
endpackage

// [logic/event_log.sv]
`timescale 1ns/1ns
module event_log #(parameter int DEPTH = 4095, parameter int W = 18)
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_clr,
   input wire logic i_wr,
   input wire logic [W-1:0] i_data,
   input wire logic [11:0] i_rd_idx,
   output logic [W-1:0] o_rd_data,
   output logic [11:0] o_count
);
   logic [W-1:0] mem_ff [DEPTH];
   logic [11:0] wp_ff;
   logic [11:0] cnt_ff;
   logic [11:0] nxt_wp;
   logic [11:0] nxt_cnt;

   // oldest entries are overwritten once full; count saturates at capacity
   always_comb
   begin
      nxt_wp = wp_ff;
      nxt_cnt = cnt_ff;
      if (i_clr)
      begin
         nxt_wp = 12'h000;
         nxt_cnt = 12'h000;
      end
      else if (i_wr)
      begin
         nxt_wp = (wp_ff == 12'(DEPTH - 1)) ? 12'h000 : wp_ff + 12'h001;
         if (cnt_ff != 12'(DEPTH))
            nxt_cnt = cnt_ff + 12'h001;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         wp_ff <= 12'h000;
         cnt_ff <= 12'h000;
      end
      else
      begin
         wp_ff <= nxt_wp;
         cnt_ff <= nxt_cnt;
      end
      if (i_wr && !i_clr)
         mem_ff[wp_ff] <= i_data;
      o_rd_data <= (i_rd_idx < 12'(DEPTH)) ? mem_ff[i_rd_idx] : '0;
   end

   assign o_count = cnt_ff;
endmodule // event_log

// [logic/loop_supervision_annunciator.sv]
// The Wishbone slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`include "annunciator_defines.svh"
module loop_supervision_annunciator #(
   parameter int unsigned LOGIC_PERIOD = `LOGIC_PERIOD_CYC,
   parameter int unsigned HB_PERIOD = `HB_PERIOD_CYC,
   parameter int unsigned TIME_PERIOD = `TIME_PERIOD_CYC,
   parameter int N_COND = 16
)
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire annunciator_pkg::wb_req_t i_wb,
   output annunciator_pkg::wb_rsp_t o_wb,
   input wire logic [N_COND-1:0] i_alarm_cond,
   input wire logic [N_COND-1:0] i_fault_cond,
   input wire logic i_ctrl_fault,
   input wire logic i_device_offline,
   input wire logic i_reset_btn,
   input wire logic i_hb_rx_a,
   input wire logic i_hb_rx_b,
   input wire logic i_page_done,
   input wire logic i_last_page,
   output logic o_hb_tx_a,
   output logic o_hb_tx_b,
   output logic o_hb_time,
   output logic [31:0] o_time,
   output logic o_page_start,
   output logic o_page_first,
   output logic [N_COND-1:0] o_alarm_led,
   output logic [N_COND-1:0] o_fault_led,
   output logic o_trouble_led,
   output logic o_loop_fault_led,
   output logic o_offline_msg,
   output logic o_trouble_tone,
   output logic o_alarm_tone,
   output logic o_trouble_relay,
   output logic o_ctrl_reset
);
   logic logic_tick;
   logic hb_tick;
   logic time_tick;

   period_tick #(.PERIOD(LOGIC_PERIOD)) u_logic_tick
   (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .o_tick(logic_tick)
   );
   period_tick #(.PERIOD(HB_PERIOD)) u_hb_tick
   (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .o_tick(hb_tick)
   );
   period_tick #(.PERIOD(TIME_PERIOD)) u_time_tick
   (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .o_tick(time_tick)
   );

   // condition latches
   logic [N_COND-1:0] alarm_lat_ff, nxt_alarm_lat;
   logic [N_COND-1:0] fault_lat_ff, nxt_fault_lat;
   logic [2:0] sys_lat_ff, nxt_sys_lat;
   logic btn_ff;
   logic ctrl_reset_ff, nxt_ctrl_reset;
   logic hb_pending_ff, nxt_hb_pending;
   logic loop_fault;
   logic [2:0] sys_now;
   logic all_clear;
   logic press;

   // bit b of a port counts as returned only if seen on b while sent from a
   always_comb
   begin
      nxt_hb_pending = hb_pending_ff;
      loop_fault = 1'b0;
      if (hb_tick)
      begin
         loop_fault = hb_pending_ff;
         nxt_hb_pending = 1'b1;
      end
      else if (i_hb_rx_b && hb_pending_ff)
         nxt_hb_pending = 1'b0;
   end

   assign sys_now = {i_device_offline, loop_fault, i_ctrl_fault};
   assign press = i_reset_btn && !btn_ff;
   assign all_clear = ~|((alarm_lat_ff & i_alarm_cond) | (fault_lat_ff & i_fault_cond))
                      && !i_ctrl_fault && !i_device_offline && !hb_pending_ff;

   always_comb
   begin
      nxt_alarm_lat = alarm_lat_ff | i_alarm_cond;
      nxt_fault_lat = fault_lat_ff | i_fault_cond;
      nxt_sys_lat = sys_lat_ff | sys_now;
      nxt_ctrl_reset = 1'b0;
      if (press && all_clear)
      begin
         // set wins: still-active alarms survive the clear
         nxt_alarm_lat = i_alarm_cond;
         nxt_fault_lat = i_fault_cond;
         nxt_sys_lat = sys_now;
         nxt_ctrl_reset = 1'b1;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         alarm_lat_ff <= '0;
         fault_lat_ff <= '0;
         sys_lat_ff <= '0;
         btn_ff <= 1'b0;
         ctrl_reset_ff <= 1'b0;
         hb_pending_ff <= 1'b0;
      end
      else
      begin
         alarm_lat_ff <= nxt_alarm_lat;
         fault_lat_ff <= nxt_fault_lat;
         sys_lat_ff <= nxt_sys_lat;
         btn_ff <= i_reset_btn;
         ctrl_reset_ff <= nxt_ctrl_reset;
         hb_pending_ff <= nxt_hb_pending;
      end
   end

   logic any_fault;
   logic any_alarm;
   assign any_fault = |fault_lat_ff || |sys_lat_ff;
   assign any_alarm = |alarm_lat_ff;

   // annunciation outputs registered
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         o_alarm_led <= '0;
         o_fault_led <= '0;
         o_trouble_led <= 1'b0;
         o_loop_fault_led <= 1'b0;
         o_offline_msg <= 1'b0;
         o_trouble_tone <= 1'b0;
         o_alarm_tone <= 1'b0;
         o_trouble_relay <= 1'b0;
      end
      else
      begin
         o_alarm_led <= alarm_lat_ff;
         o_alarm_tone <= any_alarm;
         o_fault_led <= fault_lat_ff;
         o_trouble_led <= any_fault;
         o_loop_fault_led <= sys_lat_ff[`FAULT_LOOP_BIT];
         o_offline_msg <= sys_lat_ff[`FAULT_OFFLINE_BIT];
         o_trouble_tone <= any_fault;
         o_trouble_relay <= !any_fault;
      end
   end
   assign o_ctrl_reset = ctrl_reset_ff;

   // heartbeat broadcast, both ports every period
   logic [31:0] time_ff, nxt_time;
   logic time_due_ff, nxt_time_due;
   always_comb
   begin
      nxt_time = time_ff + (time_tick ? 32'h0000_0001 : 32'h0000_0000);
      // time and heartbeat ticks coincide; set wins so the stamp is not lost
      nxt_time_due = time_tick || (time_due_ff && !hb_tick);
   end
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         o_hb_tx_a <= 1'b0;
         o_hb_tx_b <= 1'b0;
         o_hb_time <= 1'b0;
         time_ff <= 32'h0000_0000;
         time_due_ff <= 1'b0;
      end
      else
      begin
         o_hb_tx_a <= hb_tick;
         o_hb_tx_b <= hb_tick;
         o_hb_time <= hb_tick && time_due_ff;
         time_ff <= nxt_time;
         time_due_ff <= nxt_time_due;
      end
   end
   assign o_time = time_ff;

   // user logic execution
   annunciator_pkg::exec_state_t st_ff, nxt_st;
   logic start_ff, nxt_start;
   logic first_ff, nxt_first;
   logic restart_ff, nxt_restart;
   logic run_ff;
   logic [15:0] page_pos_ff, nxt_page_pos;
   logic [15:0] page_cnt_ff, nxt_page_cnt;

   always_comb
   begin
      nxt_st = st_ff;
      nxt_start = 1'b0;
      nxt_first = first_ff;
      nxt_restart = restart_ff;
      nxt_page_pos = page_pos_ff;
      nxt_page_cnt = page_cnt_ff;
      unique case (st_ff)
         annunciator_pkg::ST_IDLE:
            if (logic_tick && run_ff)
            begin
               nxt_st = annunciator_pkg::ST_RUN;
               nxt_start = 1'b1;
               nxt_first = restart_ff;
               nxt_restart = 1'b0;
               if (restart_ff)
                  nxt_page_pos = 16'h0000;
            end
         annunciator_pkg::ST_RUN:
            if (logic_tick)
            begin
               nxt_start = 1'b1; // resume remaining pages
               nxt_first = 1'b0;
            end
            else if (i_page_done)
            begin
               nxt_page_pos = page_pos_ff + 16'h0001;
               nxt_page_cnt = page_cnt_ff + 16'h0001;
               if (i_last_page)
               begin
                  nxt_st = annunciator_pkg::ST_DONE;
                  nxt_restart = 1'b1;
               end
               else
                  nxt_start = 1'b1; // next page fits
            end
         annunciator_pkg::ST_DONE:
            nxt_st = annunciator_pkg::ST_IDLE;
         default:
            nxt_st = annunciator_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         st_ff <= annunciator_pkg::ST_IDLE;
         start_ff <= 1'b0;
         first_ff <= 1'b0;
         restart_ff <= 1'b1;
         page_pos_ff <= 16'h0000;
         page_cnt_ff <= 16'h0000;
      end
      else
      begin
         st_ff <= nxt_st;
         start_ff <= nxt_start;
         first_ff <= nxt_first;
         restart_ff <= nxt_restart;
         page_pos_ff <= nxt_page_pos;
         page_cnt_ff <= nxt_page_cnt;
      end
   end
   assign o_page_start = start_ff;
   assign o_page_first = first_ff;

   // event log: one entry per cycle that latches any new condition, and one per control reset
   annunciator_pkg::log_entry_t log_in;
   logic log_wr;
   logic log_clr;
   logic [11:0] log_idx_ff;
   logic [17:0] log_rd;
   logic [11:0] log_cnt;
   assign log_in = '{alarm: |(nxt_alarm_lat & ~alarm_lat_ff),
                     fault: |(nxt_fault_lat & ~fault_lat_ff) || |(nxt_sys_lat & ~sys_lat_ff),
                     cond: 16'(i_alarm_cond | i_fault_cond)};
   assign log_wr = log_in.alarm || log_in.fault || ctrl_reset_ff;

   event_log #(.DEPTH(`LOG_DEPTH), .W(18)) u_log
   (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_clr(log_clr),
      .i_wr(log_wr),
      .i_data(log_in),
      .i_rd_idx(log_idx_ff),
      .o_rd_data(log_rd),
      .o_count(log_cnt)
   );

   // wishbone slave, ack one cycle after strobe; writes land on the acked edge
   localparam logic [31:0] CTRL_INIT = `CTRL_RESET;
   logic ack_ff;
   logic [31:0] rdat_ff, nxt_rdat;
   logic wr_hit;
   assign wr_hit = i_wb.cyc && i_wb.stb && i_wb.we && ack_ff;
   assign log_clr = wr_hit && i_wb.adr[7:0] == `REG_CTRL && i_wb.sel[0] && i_wb.dat[`CTRL_LOG_CLR_BIT];

   always_comb
   begin
      unique case (i_wb.adr[7:0])
         `REG_CTRL: nxt_rdat = {31'h0000_0000, run_ff};
         `REG_STATUS: nxt_rdat = {23'h00_0000, st_ff, o_trouble_relay, any_alarm, any_fault, sys_lat_ff, all_clear};
         `REG_FAULT_LATCH: nxt_rdat = 32'(fault_lat_ff);
         `REG_ALARM_LATCH: nxt_rdat = 32'(alarm_lat_ff);
         `REG_LOG_COUNT: nxt_rdat = {20'h0_0000, log_cnt};
         `REG_LOG_INDEX: nxt_rdat = {20'h0_0000, log_idx_ff};
         `REG_LOG_DATA: nxt_rdat = {14'h0000, log_rd};
         `REG_PAGE_COUNT: nxt_rdat = {16'h0000, page_cnt_ff};
         `REG_PAGE_POS: nxt_rdat = {16'h0000, page_pos_ff};
         `REG_TIME: nxt_rdat = time_ff;
         default: nxt_rdat = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         ack_ff <= 1'b0;
         rdat_ff <= 32'h0000_0000;
         run_ff <= CTRL_INIT[`CTRL_RUN_BIT];
         log_idx_ff <= 12'h000;
      end
      else
      begin
         ack_ff <= i_wb.cyc && i_wb.stb && !ack_ff;
         rdat_ff <= nxt_rdat;
         if (wr_hit && i_wb.sel[0] && i_wb.adr[7:0] == `REG_CTRL)
            run_ff <= i_wb.dat[`CTRL_RUN_BIT];
         if (wr_hit && i_wb.adr[7:0] == `REG_LOG_INDEX)
            log_idx_ff <= i_wb.dat[11:0];
      end
   end
   assign o_wb.ack = ack_ff;
   assign o_wb.dat = rdat_ff;

   alarm_held_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (|i_alarm_cond) |=> ##1 ((o_alarm_led & $past(i_alarm_cond, 2)) == $past(i_alarm_cond, 2)))
      else $error("active alarm not shown");
   relay_drop_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (|i_fault_cond) |=> ##1 !o_trouble_relay) else $error("trouble relay not dropped");
   latch_keep_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      !(press && all_clear) |=> ((alarm_lat_ff & $past(alarm_lat_ff)) == $past(alarm_lat_ff))
         && ((fault_lat_ff & $past(fault_lat_ff)) == $past(fault_lat_ff))) else $error("latch lost");
   reset_gate_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      o_ctrl_reset |-> $past(all_clear) && $past(press)) else $error("reset while shown active");
   hb_both_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      o_hb_tx_a == o_hb_tx_b) else $error("heartbeat ports differ");
   loop_latch_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      loop_fault |=> sys_lat_ff[`FAULT_LOOP_BIT]) else $error("lost heartbeat not latched");
   time_beat_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      o_hb_time |-> o_hb_tx_a && o_hb_tx_b) else $error("time stamp without heartbeat");
endmodule // loop_supervision_annunciator

// [logic/period_tick.sv]
`timescale 1ns/1ns
module period_tick #(parameter int unsigned PERIOD = 10)
(
   input wire logic i_mclk,
   input wire logic i_rst,
   output logic o_tick
);
   logic [31:0] cnt_ff;
   logic [31:0] nxt_cnt;
   logic nxt_tick;

   always_comb
   begin
      nxt_tick = (cnt_ff == PERIOD - 1);
      nxt_cnt = nxt_tick ? 32'h0000_0000 : cnt_ff + 32'h0000_0001;
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         cnt_ff <= 32'h0000_0000;
         o_tick <= 1'b0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         o_tick <= nxt_tick;
      end
   end
endmodule // period_tick

// [test/field_loop_model.sv]
`timescale 1ns/1ns
// timeouts and intervals are scaled down to bench cycles
module field_loop_model #(
   parameter int unsigned HOP_DELAY = 2,
   parameter int unsigned LOSS_CYC = 25,
   parameter int unsigned SWAP_CYC = 12,
   parameter int unsigned ISO_TIMEOUT = 100,
   parameter int unsigned N_DEV = 8,
   parameter int unsigned BASE_CYC = 4
)
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_tx_a,
   input wire logic i_tx_b,
   input wire logic i_cut,
   output logic o_rx_a,
   output logic o_rx_b,
   output logic o_offline,
   output logic [1:0] o_iso_open
);
   // status interval grows with the device count on the loop
   localparam int unsigned REPORT_CYC = (N_DEV > 200) ? 3 * BASE_CYC : ((N_DEV > 100) ? 2 * BASE_CYC : BASE_CYC);
   logic [7:0] a_to_b_ff;
   logic [7:0] b_to_a_ff;
   logic [7:0] rep_tmr_ff;
   logic [7:0] rep_age_ff;
   logic [15:0] quiet_ff;
   logic [15:0] iso_ff;
   logic iso_en_ff;
   logic open_a_ff;
   logic open_b_ff;
   logic hb_seen;

   // a heartbeat is heard only through a port whose relay is closed
   assign hb_seen = !i_cut && ((i_tx_a && !open_a_ff) || (i_tx_b && !open_b_ff));

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         rep_tmr_ff <= 8'h00;
         rep_age_ff <= 8'h00;
      end
      else
      begin
         rep_tmr_ff <= (rep_tmr_ff == 8'(REPORT_CYC - 1)) ? 8'h00 : rep_tmr_ff + 8'h01;
         if (rep_tmr_ff == 8'h00 && !i_cut)
            rep_age_ff <= 8'h00;
         else if (rep_age_ff != 8'hff)
            rep_age_ff <= rep_age_ff + 8'h01;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         quiet_ff <= 16'h0000;
         iso_ff <= 16'h0000;
         iso_en_ff <= 1'b1;
         open_a_ff <= 1'b0;
         open_b_ff <= 1'b0;
      end
      else if (hb_seen)
      begin
         quiet_ff <= 16'h0000;
         iso_ff <= 16'h0000;
         iso_en_ff <= 1'b1;
         open_a_ff <= 1'b0;
         open_b_ff <= 1'b0;
      end
      else
      begin
         if (quiet_ff != 16'hffff)
            quiet_ff <= quiet_ff + 16'h0001;
         if (iso_en_ff && quiet_ff >= 16'(LOSS_CYC))
         begin
            iso_ff <= iso_ff + 16'h0001;
            if (iso_ff == 16'(ISO_TIMEOUT - 1))
            begin
               iso_en_ff <= 1'b0;
               open_a_ff <= 1'b0;
               open_b_ff <= 1'b0;
            end
            else
            begin
               open_a_ff <= ((iso_ff / SWAP_CYC) % 2) == 0;
               open_b_ff <= ((iso_ff / SWAP_CYC) % 2) != 0;
            end
         end
      end
   end

   // each heartbeat crosses the devices of the loop; a double cut stops both directions
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         a_to_b_ff <= 8'h00;
         b_to_a_ff <= 8'h00;
      end
      else
      begin
         a_to_b_ff <= {a_to_b_ff[6:0], i_tx_a & ~i_cut};
         b_to_a_ff <= {b_to_a_ff[6:0], i_tx_b & ~i_cut};
      end
   end

   assign o_rx_b = a_to_b_ff[HOP_DELAY-1];
   assign o_rx_a = b_to_a_ff[HOP_DELAY-1];
   // devices between the cuts go silent; two missed reports mean offline
   assign o_offline = rep_age_ff > 8'(2 * REPORT_CYC);
   assign o_iso_open = {open_b_ff, open_a_ff};
endmodule // field_loop_model

// [test/loop_supervision_annunciator_tb.sv]
`timescale 1ns/1ns
`include "annunciator_defines.svh"
module loop_supervision_annunciator_tb;
   localparam int unsigned LP = 50;
   localparam int unsigned HP = 10;
   localparam int unsigned TP = 40;
   logic i_mclk, i_rst, ctrl_fault, reset_btn, page_done, last_page, cut;
   annunciator_pkg::wb_req_t wb;
   annunciator_pkg::wb_rsp_t rsp;
   logic [15:0] alarm_cond, fault_cond, alarm_led, fault_led;
   logic hb_rx_a, hb_rx_b, offline, hb_tx_a, hb_tx_b, hb_time, page_start, page_first;
   logic trouble_led, loop_led, offline_msg, trouble_tone, alarm_tone, relay, ctrl_reset;
   logic [31:0] tm, q, c0;
   logic [1:0] iso_open;
   int fail_count, n_compared, cycles, n_page, n_hb_a, n_hb_b, n_rst, n_time, pg_cnt, w0, w1;

   loop_supervision_annunciator #(.LOGIC_PERIOD(LP), .HB_PERIOD(HP), .TIME_PERIOD(TP)) uut (
      .i_mclk(i_mclk), .i_rst(i_rst), .i_wb(wb), .o_wb(rsp), .i_alarm_cond(alarm_cond),
      .i_fault_cond(fault_cond), .i_ctrl_fault(ctrl_fault), .i_device_offline(offline),
      .i_reset_btn(reset_btn), .i_hb_rx_a(hb_rx_a), .i_hb_rx_b(hb_rx_b), .i_page_done(page_done),
      .i_last_page(last_page), .o_hb_tx_a(hb_tx_a), .o_hb_tx_b(hb_tx_b), .o_hb_time(hb_time),
      .o_time(tm), .o_page_start(page_start), .o_page_first(page_first), .o_alarm_led(alarm_led),
      .o_fault_led(fault_led), .o_trouble_led(trouble_led), .o_loop_fault_led(loop_led),
      .o_offline_msg(offline_msg), .o_trouble_tone(trouble_tone), .o_alarm_tone(alarm_tone),
      .o_trouble_relay(relay), .o_ctrl_reset(ctrl_reset));

   field_loop_model #(.HOP_DELAY(2)) loop_far (.i_mclk(i_mclk), .i_rst(i_rst), .i_tx_a(hb_tx_a),
      .i_tx_b(hb_tx_b), .i_cut(cut), .o_rx_a(hb_rx_a), .o_rx_b(hb_rx_b), .o_offline(offline),
      .o_iso_open(iso_open));

   initial
   begin
      i_mclk = 1'b0;
      forever #20 i_mclk = ~i_mclk;
   end

   task close_out;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task wb_xfer(input logic [31:0] a, input logic [31:0] d, input logic we, output logic [31:0] r);
      @(posedge i_mclk);
      wb <= '{adr: a, dat: d, sel: 4'hf, we: we, cyc: 1'b1, stb: 1'b1};
      // only the bench timeout ends this wait
      do @(posedge i_mclk); while (rsp.ack !== 1'b1);
      r = rsp.dat;
      wb <= '0;
   endtask

   task wait_cyc(input int n);
      repeat (n) @(posedge i_mclk);
   endtask

   // press away from a heartbeat in flight, which would hold the reset off
   task press;
      do @(posedge i_mclk); while (hb_tx_a !== 1'b1);
      wait_cyc(3);
      reset_btn <= 1'b1;
      wait_cyc(2);
      reset_btn <= 1'b0;
      wait_cyc(4);
   endtask

   always @(posedge i_mclk)
   begin
      cycles++;
      if (cycles > 5000)
      begin
         fail_count++;
         close_out();
      end
   end

   // pulses counted at the falling edge, clear of the edge that launches them
   always @(negedge i_mclk)
   begin
      n_hb_a += hb_tx_a;
      n_hb_b += hb_tx_b;
      n_time += hb_time;
      n_rst += ctrl_reset;
      n_page += page_start;
   end

   // page runner: each page ends a cycle after its start, the third is the last
   always @(posedge i_mclk)
   begin
      page_done <= page_start;
      last_page <= page_start && pg_cnt == 2;
      if (page_start === 1'b1)
      begin
         if (pg_cnt == 0)
            chk(page_first, 1'b1);
         pg_cnt = (pg_cnt == 2) ? 0 : pg_cnt + 1;
      end
   end

   initial
   begin
      wb = '0;
      alarm_cond = '0;
      fault_cond = '0;
      {ctrl_fault, reset_btn, page_done, last_page, cut} = '0;
      {fail_count, n_compared, cycles, n_page, n_hb_a, n_hb_b, n_rst, n_time, pg_cnt} = '0;
      i_rst = 1'b1;
      wait_cyc(8);
      i_rst <= 1'b0;
      wait_cyc(3);
      chk(relay, 1'b1);
      wb_xfer(`REG_CTRL, 32'h0000_0000, 1'b0, q);
      chk(q, `CTRL_RESET);
      wb_xfer(32'h0000_0040, 32'hffff_ffff, 1'b1, q);
      wb_xfer(32'h0000_0040, 32'h0000_0000, 1'b0, q);
      chk(q, 32'h0000_0000);
      wait_cyc(LP);
      w0 = n_page;
      wait_cyc(LP);
      chk(n_page - w0, 3);
      w0 = n_hb_a;
      w1 = n_hb_b;
      wait_cyc(HP * 5);
      chk(n_hb_a - w0, 5);
      chk(n_hb_b - w1, 5);
      w0 = n_time;
      c0 = tm;
      wait_cyc(TP * 3);
      chk(n_time - w0, 3);
      chk(tm - c0, 3);
      wb_xfer(`REG_LOG_COUNT, 32'h0000_0000, 1'b0, c0);
      alarm_cond <= 16'h0020;
      wait_cyc(3);
      chk(alarm_led, 16'h0020);
      chk(alarm_tone, 1'b1);
      alarm_cond <= 16'h0000;
      wait_cyc(3);
      chk(alarm_led, 16'h0020);
      wb_xfer(`REG_ALARM_LATCH, 32'h0000_0000, 1'b0, q);
      chk(q, 32'h0000_0020);
      wb_xfer(`REG_LOG_COUNT, 32'h0000_0000, 1'b0, q);
      chk(q > c0, 1'b1);
      fault_cond <= 16'h0008;
      @(posedge i_mclk);
      fault_cond <= 16'h0000;
      wait_cyc(3);
      chk(fault_led, 16'h0008);
      chk({trouble_led, trouble_tone, relay}, 3'b110);
      alarm_cond <= 16'h0020;
      w0 = n_rst;
      press();
      chk(n_rst - w0, 0);
      chk(alarm_led, 16'h0020);
      alarm_cond <= 16'h0000;
      press();
      chk(n_rst - w0, 1);
      wait_cyc(2);
      chk({alarm_led, fault_led}, 32'h0000_0000);
      chk({alarm_tone, trouble_tone, relay}, 3'b001);
      cut <= 1'b1;
      ctrl_fault <= 1'b1;
      wait_cyc(HP * 3);
      chk({loop_led, offline_msg, relay}, 3'b110);
      wb_xfer(`REG_STATUS, 32'h0000_0000, 1'b0, q);
      chk((q >> 1) & 32'h0000_0007, 32'h0000_0007);
      chk(iso_open == 2'b01 || iso_open == 2'b10, 1'b1);
      cut <= 1'b0;
      ctrl_fault <= 1'b0;
      wait_cyc(HP * 3);
      chk(offline_msg, 1'b1);
      chk(iso_open, 2'b00);
      press();
      wait_cyc(2);
      chk({loop_led, offline_msg, relay}, 3'b001);
      close_out();
   end
endmodule // loop_supervision_annunciator_tb
